// *** logic/arc_pkg.sv ***
// Constants, state type and arc table for the two-axis arc interpolator
package arc_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_PARAM = 8'h04;
    localparam logic [7:0] ADDR_XTGT  = 8'h08;
    localparam logic [7:0] ADDR_YTGT  = 8'h0C;
    localparam logic [7:0] ADDR_STAT  = 8'h10;
    localparam logic [7:0] ADDR_XPOS  = 8'h14;
    localparam logic [7:0] ADDR_YPOS  = 8'h18;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CTRL_EN  = 0;
    localparam int CTRL_ABS = 1;
    localparam int CTRL_GRP = 2;
    localparam int STAT_XDONE = 0;
    localparam int STAT_YDONE = 1;
    localparam int STAT_XERR  = 2;
    localparam int STAT_YERR  = 3;
    localparam int STAT_BUSY  = 4;
    localparam int MODE_LO = 0;
    localparam int MODE_HI = 15;
    localparam int TIME_LO = 16;
    localparam int TIME_HI = 31;
    localparam logic [31:0] CTRL_RST  = 32'h0;
    localparam logic [31:0] PARAM_RST = 32'h0;
    localparam logic [31:0] TGT_RST   = 32'h0;
    localparam logic [31:0] POS_RST   = 32'h0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ       = 100_000_000;
    localparam int CYC_PER_MS   = CLK_HZ / 1000;
    localparam int UNIT_MS      = 100;
    localparam int SETUP_REL_MS = 2;
    localparam int SETUP_A10_MS = 5;
    localparam int SETUP_A20_MS = 10;

    // ****************************************
    // Limits and modes
    // ****************************************
    localparam logic [32:0] MIN_A10 = 33'h64;
    localparam logic [32:0] MAX_A10 = 33'hF4240;
    localparam logic [32:0] MIN_A20 = 33'h3E8;
    localparam logic [32:0] MAX_A20 = 33'h989680;
    localparam logic [15:0] MODE_MAX_REL = 16'h1;
    localparam logic [15:0] MODE_MAX_ABS = 16'h3;
    localparam logic [4:0]  SEG_LAST_10  = 5'h09;
    localparam logic [4:0]  SEG_LAST_20  = 5'h13;
    localparam logic [4:0]  SEG_FULL     = 5'h14;
    localparam logic [16:0] FRAC_ONE     = 17'h10000;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_RUN   = 2'b11,
        ST_HOLD  = 2'b10
    } arc_state_t;

    // Sine of k * 4.5 degrees, 16 fraction bits
    function automatic logic [16:0] sin_q16(input logic [4:0] k);
        logic [16:0] s;
        case (k)
            5'h00: s = 17'h00000;
            5'h01: s = 17'h01416;
            5'h02: s = 17'h0280C;
            5'h03: s = 17'h03BC3;
            5'h04: s = 17'h04F1C;
            5'h05: s = 17'h061F8;
            5'h06: s = 17'h07439;
            5'h07: s = 17'h085C3;
            5'h08: s = 17'h09679;
            5'h09: s = 17'h0A642;
            5'h0A: s = 17'h0B505;
            5'h0B: s = 17'h0C2AA;
            5'h0C: s = 17'h0CF1C;
            5'h0D: s = 17'h0DA46;
            5'h0E: s = 17'h0E418;
            5'h0F: s = 17'h0EC83;
            5'h10: s = 17'h0F378;
            5'h11: s = 17'h0F8ED;
            5'h12: s = 17'h0FCD9;
            5'h13: s = 17'h0FF36;
            default: s = FRAC_ONE;
        endcase
        return s;
    endfunction

endpackage

// *** logic/chord_axis_dda.sv ***
// Even pulse spreader for one axis over one chord
`timescale 1ns/100ps
module chord_axis_dda #(
    parameter int CW = 33,
    parameter int LW = 32
)
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          reset,
    // Chord control
    input  wire logic          run,
    input  wire logic          load,
    input  wire logic [CW-1:0] count,
    input  wire logic [LW-1:0] len,
    // Step out
    output logic               step
);

    if (CW < LW || LW < 2)
    begin : g_bad_param
        $error("Count width must be at least the length width");
    end

    logic [CW-1:0] cnt_reg;
    logic [CW:0]   acc_reg;

    wire [CW:0] len_ext = {{(CW + 1 - LW){1'b0}}, len};
    wire [CW:0] sum     = acc_reg + {1'b0, cnt_reg};
    wire        hit     = sum >= len_ext;

    // Plain rate, no ramp: count pulses spread over len cycles
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cnt_reg <= '0;
            acc_reg <= '0;
            step    <= 1'b0;
        end
        else
        begin
            step    <= run & hit;
            cnt_reg <= load ? count : cnt_reg;
            acc_reg <= (load | ~run) ? '0 : (hit ? sum - len_ext : sum);
        end
    end

endmodule

// *** logic/two_axis_arc_interpolator.sv ***
// Two-axis 90-degree arc pulse generator with a Wishbone register file
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - Relative targets are signed 32-bit; position counts up forward, down in reverse.
// - Relative mode 0 is clockwise, 1 counterclockwise, 20 chords; others rejected.
// - Relative direction output is low for positive, high for negative motion.
// - Relative commands use group one only: X pulse, X dir, Y pulse, Y dir.
// - Relative commands wait about 2 ms of set-up before moving.
// - One command draws exactly one quarter arc; figures need repeated commands.
// - No start frequency and no ramps; rates follow the interpolation.
// - The absolute variant only produces pulse plus direction.
// - Absolute direction comes from comparing target with present position.
// - Absolute mode: 0/1 ten chords, 2/3 twenty chords; others rejected.
// - Absolute commands may use either output group, same pin order.
// - After completion direction outputs hold until enable is cleared.
// - Absolute direction high is positive; even modes clockwise, odd counterclockwise.
// - Ten-chord arcs wait about 5 ms; reject pulse counts outside 100 to 1,000,000.
// - Absolute twenty-chord arcs wait about 10 ms; reject counts outside 1,000 to 10,000,000.
// - Each channel raises a done flag when its arc is finished.
// - Each channel raises an error flag when parameters are rejected.
module two_axis_arc_interpolator
    import arc_pkg::*;
#(
    parameter int UNIT_CYC      = UNIT_MS * CYC_PER_MS,
    parameter int SETUP_REL_CYC = SETUP_REL_MS * CYC_PER_MS,
    parameter int SETUP_A10_CYC = SETUP_A10_MS * CYC_PER_MS,
    parameter int SETUP_A20_CYC = SETUP_A20_MS * CYC_PER_MS
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Output group one
    output logic             x_pulse_out_group1,
    output logic             x_dir_out_group1,
    output logic             y_pulse_out_group1,
    output logic             y_dir_out_group1,
    // Output group two
    output logic             x_pulse_out_group2,
    output logic             x_dir_out_group2,
    output logic             y_pulse_out_group2,
    output logic             y_dir_out_group2
);

    if (UNIT_CYC < 20 || UNIT_CYC % 20 != 0 || SETUP_REL_CYC < 1 || SETUP_A10_CYC < 1 || SETUP_A20_CYC < 1)
    begin : g_bad_param
        $error("Unit time must be a positive multiple of 20 cycles");
    end

    localparam logic [31:0] LEN_10 = 32'(UNIT_CYC / 10);
    localparam logic [31:0] LEN_20 = 32'(UNIT_CYC / 20);

    // ****************************************
    // Storage
    // ****************************************
    logic [31:0] ctrl_reg, param_reg, len_reg, cyc_reg, setup_reg;
    logic [31:0] tgt_reg [2];
    logic [31:0] pos_reg [2];
    logic [32:0] mag_reg [2];
    logic [32:0] cum_reg [2];
    logic [1:0]  neg_reg, done_reg, err_reg, fin_reg;
    logic        seg20_reg, ccw_reg, grp_reg, rel_reg;
    logic [4:0]  chord_reg;
    arc_state_t  state_reg, state_next;
    logic [31:0] rd_mux, status_w;
    logic [32:0] mag_w [2];
    logic [32:0] cum_w [2];
    logic [32:0] cnt_w [2];
    logic [1:0]  neg_w, step;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction

    // ****************************************
    // Bus decode
    // ****************************************
    wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    wire wr_ctrl   = bus_wr & (wb_adr_i == ADDR_CTRL);
    wire wr_param  = bus_wr & (wb_adr_i == ADDR_PARAM);
    wire idle      = state_reg == ST_IDLE;
    wire run       = state_reg == ST_RUN;

    always_comb
    begin
        status_w             = 32'h0;
        status_w[STAT_XDONE] = done_reg[0];
        status_w[STAT_YDONE] = done_reg[1];
        status_w[STAT_XERR]  = err_reg[0];
        status_w[STAT_YERR]  = err_reg[1];
        status_w[STAT_BUSY]  = state_reg == ST_SETUP || run;
    end

    always_comb
    begin
        if (wb_adr_i == ADDR_CTRL)
            rd_mux = ctrl_reg;
        else if (wb_adr_i == ADDR_PARAM)
            rd_mux = param_reg;
        else if (wb_adr_i == ADDR_XTGT)
            rd_mux = tgt_reg[0];
        else if (wb_adr_i == ADDR_YTGT)
            rd_mux = tgt_reg[1];
        else if (wb_adr_i == ADDR_STAT)
            rd_mux = status_w;
        else if (wb_adr_i == ADDR_XPOS)
            rd_mux = pos_reg[0];
        else if (wb_adr_i == ADDR_YPOS)
            rd_mux = pos_reg[1];
        else
            rd_mux = 32'h0;
    end

    // Every access is answered one cycle later; unmapped reads give zero
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            wb_ack_o  <= 1'b0;
            wb_dat_o  <= 32'h0;
            ctrl_reg  <= CTRL_RST;
            param_reg <= PARAM_RST;
        end
        else
        begin
            wb_ack_o  <= bus_req;
            wb_dat_o  <= bus_req ? rd_mux : wb_dat_o;
            ctrl_reg  <= wr_ctrl ? merge(ctrl_reg, wb_dat_i, wb_sel_i) : ctrl_reg;
            param_reg <= wr_param ? merge(param_reg, wb_dat_i, wb_sel_i) : param_reg;
        end
    end

    // ****************************************
    // Command check
    // ****************************************
    wire        en        = ctrl_reg[CTRL_EN];
    wire        rel       = ~ctrl_reg[CTRL_ABS];
    wire [15:0] mode      = param_reg[MODE_HI:MODE_LO];
    wire [15:0] utime     = param_reg[TIME_HI:TIME_LO];
    wire        seg20     = rel | mode[1];
    wire        mode_bad  = mode > (rel ? MODE_MAX_REL : MODE_MAX_ABS);
    wire [32:0] mag_max   = (mag_w[0] > mag_w[1]) ? mag_w[0] : mag_w[1];
    wire        bad_10    = mag_max < MIN_A10 || mag_max > MAX_A10;
    wire        bad_20    = mag_max < MIN_A20 || mag_max > MAX_A20;
    wire        range_bad = ~rel & (seg20 ? bad_20 : bad_10);
    wire        start_bad = mode_bad | range_bad | (utime == 16'h0);
    wire        start     = idle & en;

    // Chord time is the duration split evenly across the chords
    wire [47:0] len_prod  = {32'h0, utime} * {16'h0, (seg20 ? LEN_20 : LEN_10)};

    // Settling time depends on variant and resolution
    wire [31:0] setup_len = rel ? 32'(SETUP_REL_CYC) : (seg20 ? 32'(SETUP_A20_CYC) : 32'(SETUP_A10_CYC));

    // ****************************************
    // Chord sequencing
    // ****************************************
    wire        chord_end = run & (cyc_reg == len_reg - 32'h1);
    wire        last      = chord_reg == (seg20_reg ? SEG_LAST_20 : SEG_LAST_10);
    wire        fin       = chord_end & last;
    wire        load      = (state_reg == ST_SETUP && setup_reg == 32'h0) | (chord_end & ~last);
    wire [4:0]  ld_chord  = run ? chord_reg + 5'h1 : 5'h0;
    wire [4:0]  pt_idx    = seg20_reg ? ld_chord + 5'h1 : {ld_chord[3:0], 1'b0} + 5'h2;
    wire [16:0] frac_s    = sin_q16(pt_idx);
    wire [16:0] frac_c    = FRAC_ONE - sin_q16(SEG_FULL - pt_idx);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (en)
                    state_next = start_bad ? ST_HOLD : ST_SETUP;
            ST_SETUP:
                if (!en)
                    state_next = ST_IDLE;
                else if (setup_reg == 32'h0)
                    state_next = ST_RUN;
            ST_RUN:
                if (!en)
                    state_next = ST_IDLE;
                else if (fin)
                    state_next = ST_HOLD;
            ST_HOLD:
                if (!en)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ST_IDLE;
            setup_reg <= 32'h0;
            len_reg   <= 32'h0;
            cyc_reg   <= 32'h0;
            chord_reg <= 5'h0;
            fin_reg   <= 2'b00;
        end
        else
        begin
            state_reg <= state_next;
            setup_reg <= start ? setup_len : (setup_reg != 32'h0 ? setup_reg - 32'h1 : setup_reg);
            len_reg   <= start ? len_prod[31:0] : len_reg;
            cyc_reg   <= load ? 32'h0 : (run ? cyc_reg + 32'h1 : cyc_reg);
            chord_reg <= load ? ld_chord : chord_reg;
            fin_reg   <= {fin_reg[0], fin};
        end
    end

    // Latch the command at start; flags clear only when a new command starts
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            seg20_reg <= 1'b0;
            ccw_reg   <= 1'b0;
            grp_reg   <= 1'b0;
            rel_reg   <= 1'b1;
            neg_reg   <= 2'b00;
            done_reg  <= 2'b00;
            err_reg   <= 2'b00;
        end
        else if (start)
        begin
            seg20_reg <= seg20;
            ccw_reg   <= mode[0];
            grp_reg   <= ~rel & ctrl_reg[CTRL_GRP];
            rel_reg   <= rel;
            neg_reg   <= neg_w;
            done_reg  <= 2'b00;
            err_reg   <= {2{start_bad}};
        end
        else if (fin_reg[1])
            done_reg  <= 2'b11;
    end

    // ****************************************
    // Axes
    // ****************************************
    for (genvar a = 0; a < 2; a++)
    begin : g_axis
        wire [7:0]  tgt_addr = (a == 0) ? ADDR_XTGT : ADDR_YTGT;
        wire [7:0]  pos_addr = (a == 0) ? ADDR_XPOS : ADDR_YPOS;
        // Relative counts from zero, absolute from present position
        wire [32:0] delta = {tgt_reg[a][31], tgt_reg[a]} - (rel ? 33'h0 : {pos_reg[a][31], pos_reg[a]});
        // Even modes lead with sine on X, odd modes swap the axes
        wire [16:0] frac  = (((a == 1) ? 1'b1 : 1'b0) ^ ccw_reg) ? frac_c : frac_s;
        wire [49:0] prod  = {17'h0, mag_reg[a]} * {33'h0, frac};

        assign neg_w[a] = delta[32];
        assign mag_w[a] = delta[32] ? 33'h0 - delta : delta;
        assign cum_w[a] = prod[48:16];
        assign cnt_w[a] = prod[48:16] - cum_reg[a];

        always_ff @(posedge mclk or posedge reset)
        begin
            if (reset)
            begin
                tgt_reg[a] <= TGT_RST;
                pos_reg[a] <= POS_RST;
                mag_reg[a] <= 33'h0;
                cum_reg[a] <= 33'h0;
            end
            else
            begin
                tgt_reg[a] <= (bus_wr && wb_adr_i == tgt_addr) ? merge(tgt_reg[a], wb_dat_i, wb_sel_i) : tgt_reg[a];
                // A step outranks a software preset, which is only taken while idle
                if (step[a])
                    pos_reg[a] <= neg_reg[a] ? pos_reg[a] - 32'h1 : pos_reg[a] + 32'h1;
                else if (idle && bus_wr && wb_adr_i == pos_addr)
                    pos_reg[a] <= merge(pos_reg[a], wb_dat_i, wb_sel_i);
                mag_reg[a] <= start ? mag_w[a] : mag_reg[a];
                cum_reg[a] <= start ? 33'h0 : (load ? cum_w[a] : cum_reg[a]);
            end
        end

        chord_axis_dda #(.CW(33), .LW(32)) u_dda (
            .mclk  (mclk),
            .reset (reset),
            .run   (run),
            .load  (load),
            .count (cnt_w[a]),
            .len   (len_reg),
            .step  (step[a])
        );
    end

    // ****************************************
    // Pins
    // ****************************************
    wire       dir_on = ~idle & ~err_reg[0];
    wire [1:0] dir_w  = rel_reg ? neg_reg : ~neg_reg;

    // Pulse plus direction only; one group at a time
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            x_pulse_out_group1 <= 1'b0;
            x_dir_out_group1   <= 1'b0;
            y_pulse_out_group1 <= 1'b0;
            y_dir_out_group1   <= 1'b0;
            x_pulse_out_group2 <= 1'b0;
            x_dir_out_group2   <= 1'b0;
            y_pulse_out_group2 <= 1'b0;
            y_dir_out_group2   <= 1'b0;
        end
        else
        begin
            x_pulse_out_group1 <= step[0] & ~grp_reg;
            x_dir_out_group1   <= dir_on & dir_w[0] & ~grp_reg;
            y_pulse_out_group1 <= step[1] & ~grp_reg;
            y_dir_out_group1   <= dir_on & dir_w[1] & ~grp_reg;
            x_pulse_out_group2 <= step[0] & grp_reg;
            x_dir_out_group2   <= dir_on & dir_w[0] & grp_reg;
            y_pulse_out_group2 <= step[1] & grp_reg;
            y_dir_out_group2   <= dir_on & dir_w[1] & grp_reg;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_rel_dir;
        (run && $past(run) && rel_reg) |-> x_dir_out_group1 == neg_reg[0] && y_dir_out_group1 == neg_reg[1];
    endproperty
    a_rel_dir: assert property (p_rel_dir) else $error("Relative direction wrong");

    property p_abs_dir;
        (run && $past(run) && !rel_reg && !grp_reg) |-> x_dir_out_group1 == !neg_reg[0];
    endproperty
    a_abs_dir: assert property (p_abs_dir) else $error("Absolute direction wrong");

    property p_setup;
        $rose(run) |-> $past(state_reg) == ST_SETUP && $past(setup_reg) == 32'h0;
    endproperty
    a_setup: assert property (p_setup) else $error("Motion began before set-up");

    property p_refuse;
        (idle && en && range_bad) |=> state_reg == ST_HOLD && err_reg == 2'b11;
    endproperty
    a_refuse: assert property (p_refuse) else $error("Out of range count not refused");

    property p_mode;
        (idle && en && mode_bad) |=> err_reg == 2'b11 ##1 !x_dir_out_group1 && !x_pulse_out_group1;
    endproperty
    a_mode: assert property (p_mode) else $error("Bad mode not refused");

    property p_hold;
        (state_reg == ST_HOLD && $past(state_reg) == ST_HOLD && en) |=>
            $stable({x_dir_out_group1, y_dir_out_group1, x_dir_out_group2, y_dir_out_group2});
    endproperty
    a_hold: assert property (p_hold) else $error("Direction dropped while enabled");

    property p_pos;
        (step[0] && !neg_reg[0]) |=> pos_reg[0] == $past(pos_reg[0]) + 32'h1;
    endproperty
    a_pos: assert property (p_pos) else $error("Position did not count up");

    property p_grp;
        (rel_reg && !idle) |-> !x_pulse_out_group2 && !y_pulse_out_group2 && !x_dir_out_group2;
    endproperty
    a_grp: assert property (p_grp) else $error("Relative command used group two");

    property p_pd;
        !((x_pulse_out_group1 || y_pulse_out_group1) && (x_pulse_out_group2 || y_pulse_out_group2));
    endproperty
    a_pd: assert property (p_pd) else $error("Both groups pulsing");

    property p_done;
        fin |-> ##3 done_reg == 2'b11;
    endproperty
    a_done: assert property (p_done) else $error("Done flags not raised");

    property p_one_arc;
        (state_reg == ST_HOLD && en) |=> state_reg == ST_HOLD;
    endproperty
    a_one_arc: assert property (p_one_arc) else $error("Second arc without new enable");

endmodule

// *** verification/axis_drive_model.sv ***
// Pulse-plus-direction drive model that counts steps on one axis
`timescale 1ns/100ps
module axis_drive_model
(
    // Drive pins
    input  wire logic mclk,
    input  wire logic pulse,
    // Step count seen by the drive
    output int        steps
);
    initial steps = 0;
    // Each high cycle is one step, because adjacent steps merge into one wide pulse
    always @(posedge mclk)
        if (pulse === 1'b1)
            steps <= steps + 1;
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the two-axis arc interpolator
`timescale 1ns/100ps
module testbench;
    import arc_pkg::*;
    logic        mclk, reset, req, we, ack;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, rd;
    logic [3:0]  g1, g2;
    wire  [3:0]  pl = {g2[2], g2[0], g1[2], g1[0]};
    wire  [31:0] st [4];
    int          mismatches, check_count, px, py;
    two_axis_arc_interpolator #(.UNIT_CYC(400), .SETUP_REL_CYC(20), .SETUP_A10_CYC(30), .SETUP_A20_CYC(40)) dut
    (
        .mclk(mclk), .reset(reset), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .x_pulse_out_group1(g1[0]), .x_dir_out_group1(g1[1]), .y_pulse_out_group1(g1[2]), .y_dir_out_group1(g1[3]),
        .x_pulse_out_group2(g2[0]), .x_dir_out_group2(g2[1]), .y_pulse_out_group2(g2[2]), .y_dir_out_group2(g2[3])
    );
    for (genvar i = 0; i < 4; i++)
    begin : drv
        axis_drive_model m (.mclk(mclk), .pulse(pl[i]), .steps(st[i]));
    end
    function automatic int total();
        return st[0] + st[1] + st[2] + st[3];
    endfunction
    function automatic int mag(input int v);
        return v < 0 ? -v : v;
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, e);
        check_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("BAD %0t got %0h want %0h", $time, s, e);
        end
    endtask
    task automatic stall;
        mismatches++;
        $display("BAD %0t wait ran out", $time);
        conclude;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            stall;
        rd = rdat;
        req <= 1'b0;
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do
        begin
            wb(1'b0, ADDR_STAT, 0);
            n++;
        end
        while (rd[1:0] !== 2'b11 && n < 3000);
        if (n >= 3000)
            stall;
    endtask
    task automatic launch(input logic [31:0] c, p, input int dx, dy);
        wb(1'b1, ADDR_PARAM, p);
        wb(1'b1, ADDR_XTGT, c[1] ? px + dx : dx);
        wb(1'b1, ADDR_YTGT, c[1] ? py + dy : dy);
        wb(1'b1, ADDR_CTRL, c | 32'h1);
    endtask
    task automatic run_arc(input logic [31:0] c, p, input int dx, dy);
        int         b, t0, sx, sy;
        logic [1:0] ed;
        logic [3:0] pins;
        b = (c[1] && c[2]) ? 2 : 0;
        t0 = total();
        sx = st[b];
        sy = st[b+1];
        ed = c[1] ? {dx > 0, dy > 0} : {dx < 0, dy < 0};
        launch(c, p, dx, dy);
        repeat (15) @(posedge mclk);
        pins = b ? g2 : g1;
        chk(total() - t0, 0);
        chk({pins[1], pins[3]}, ed);
        wait_done;
        chk(rd[4:0], 5'h03);
        chk(st[b] - sx, mag(dx));
        chk(st[b+1] - sy, mag(dy));
        chk(total() - t0, mag(dx) + mag(dy));
        px += dx;
        py += dy;
        wb(1'b0, ADDR_XPOS, 0);
        chk(rd, px);
        wb(1'b0, ADDR_YPOS, 0);
        chk(rd, py);
        pins = b ? g2 : g1;
        chk({pins[1], pins[3]}, ed);
        wb(1'b1, ADDR_CTRL, c);
        wb(1'b0, ADDR_STAT, 0);
        chk({g1[1], g1[3], g2[1], g2[3]}, 4'h0);
    endtask
    task automatic err_arc(input logic [31:0] c, p, input int dx, dy);
        int t0;
        t0 = total();
        launch(c, p, dx, dy);
        // Longer than any set-up, so a wrongly started arc would show pulses
        repeat (60) @(posedge mclk);
        wb(1'b0, ADDR_STAT, 0);
        chk(rd[4:0], 5'h0C);
        chk(total() - t0, 0);
        chk({g1[1], g1[3], g2[1], g2[3]}, 4'h0);
        wb(1'b1, ADDR_CTRL, c);
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        reset = 1'b1;
        {req, we, adr, wdat, mismatches, check_count, px, py} = '0;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        wb(1'b0, ADDR_STAT, 0);
        chk(rd, 32'h0);
        wb(1'b1, 8'h1C, 32'h5A5A_5A5A);
        wb(1'b0, 8'h1C, 0);
        chk(rd, 32'h0);
        $display("test regs finished");
        // Durations stay within range and above the fastest limits
        run_arc(32'h0, 32'h0002_0000, 30, -20);
        run_arc(32'h4, 32'h0002_0001, -30, 20);
        $display("test relative finished");
        run_arc(32'h2, 32'h0008_0002, 1000, -1000);
        run_arc(32'h6, 32'h0008_0003, -1000, 1000);
        run_arc(32'h6, 32'h0001_0001, 100, -100);
        run_arc(32'h2, 32'h0001_0000, -100, 100);
        $display("test absolute finished");
        err_arc(32'h0, 32'h0002_0002, 30, 30);
        err_arc(32'h2, 32'h0001_0000, 99, 50);
        err_arc(32'h2, 32'h0002_0002, 999, 10);
        err_arc(32'h2, 32'h0002_0004, 1000, 1000);
        $display("test refusals finished");
        conclude;
    end
endmodule
